// ---- core/chan_regs_pkg.sv ----
package chan_regs_pkg;
  // Register offsets within the channel map
  localparam logic [7:0] OFS_CNT_BYTE5 = 8'h85;
  localparam logic [7:0] OFS_CNT_BYTE0 = 8'h8A;
  localparam logic [7:0] OFS_UNCORR_HI = 8'h8B;
  localparam logic [7:0] OFS_UNCORR_LO = 8'h8C;
  localparam logic [7:0] OFS_EQ_BW = 8'h8D;
  localparam logic [7:0] OFS_REFCLK_EDGE = 8'h8E;
  localparam logic [7:0] OFS_EQ_BOOST = 8'h8F;
  localparam logic [7:0] OFS_COMMA_HI = 8'h90;
  localparam logic [7:0] OFS_COMMA_LO = 8'h91;
  localparam logic [7:0] OFS_RSVD_A = 8'h92;
  localparam logic [7:0] OFS_RSVD_B = 8'h93;
  localparam logic [7:0] OFS_PWR_A = 8'h94;
  localparam logic [7:0] OFS_PWR_B = 8'h95;
  localparam logic [7:0] OFS_XPNT = 8'h96;
  localparam logic [7:0] OFS_PATT_HI = 8'h97;
  localparam logic [7:0] OFS_RSVD_C = 8'h98;
  localparam logic [7:0] OFS_DIV_A = 8'h99;
  localparam logic [7:0] OFS_DIV_B = 8'h9A;
  localparam logic [7:0] OFS_EQ_CTRL_SRC = 8'h9B;
  // Reset values
  localparam logic [7:0] RST_EQ_BW = 8'h06;
  localparam logic [7:0] RST_REFCLK_EDGE = 8'h1C;
  localparam logic [7:0] RST_XPNT = 8'h04;
  localparam logic [7:0] RST_RSVD_C = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h3F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Field positions
  localparam int BW_MSB_BIT = 6;
  localparam int BW_LSB_BIT = 2;
  localparam int REFSEL_BIT = 6;
  localparam int LOOPTHRU_BIT = 5;
  localparam int EDGE_HI = 4;
  localparam int EDGE_LO = 2;
  localparam int GAIN_HI = 1;
  localparam int ROLE_BIT = 5;
  localparam int XEN_BIT = 4;
  localparam int BUF_HI = 3;
  localparam int BUF_LO = 2;
  localparam int PERIOD_HI = 7;
  localparam int PERIOD_LO = 4;
  localparam int BIT_CNT_W = 47;
  localparam int THRESH_W = 12;
  localparam int WINDOW_BASE_LOG2 = 5; // Window is 2^period times 32 bits
  localparam int WINDOW_W = 21;
  typedef enum logic [1:0] {BW_FULL, BW_MID, BW_ALT_MID, BW_HALF} eq_bw_t;
endpackage

// ---- core/retimer_channel_config_regs.sv ----
// Behaviour
// - 47-bit read-only checker bit count, low byte at 0x8A, higher bytes down to 0x85.
// - Bits 6 and 2 of 0x8D form equalizer bandwidth: full, mid, alt mid, half.
// - Refclk source bit: one picks own digital clock, zero picks neighbour output.
// - Loop-through enable bit activates the reference clock loop-through multiplexer.
// - Edge-rate field bits 4:2 resets to ones, gain bits 1:0 resets to zero.
// - Equalizer boost register reads adaptation value, writes ignored.
// - Check window length in bits is two to the period field, times 32.
// - Twelve-bit comma threshold from 0x90[3:0] high and 0x91 low.
// - Window and threshold apply only when comma or block lock checking enabled.
// - Crosspoint role bit: one slave, zero master; reset is master.
// - Crosspoint enable bit routes crosspoint when set, resets to zero.
// - Buffer field: none, local (reset), multi-drive, both.
// - Data source select picks quad member A to D for codes 00 to 11.
// - Control source select picks quad member's control bus, same coding.
// - Generator pattern upper byte from write-only 0x97, lower from 0x7C.
// - Freeze control holds checker counts stable for multi-byte readback.
// - Comma check enable makes comma detection an extra lock condition.
`timescale 1ns/10ps
`default_nettype none
module retimer_channel_config_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic [7:0] gen_pattern_low,
  input wire logic checker_bit_tick,
  input wire logic checker_count_freeze,
  input wire logic checker_count_clear,
  input wire logic [7:0] eq_boost_adapt,
  input wire logic comma_lock_check_enable,
  input wire logic block_lock_check_enable,
  input wire logic comma_seen,
  input wire logic cdr_lock_raw,
  output logic [1:0] eq_bandwidth,
  output logic refclk_out_source_select,
  output logic refclk_loopthrough_enable,
  output logic [2:0] tx_edge_rate_field,
  output logic [1:0] rx_gain_field,
  output logic crosspoint_role,
  output logic crosspoint_enable,
  output logic [1:0] eq_output_buffer_select,
  output logic [1:0] eq_data_source_select,
  output logic [1:0] eq_control_source_select,
  output logic [15:0] generator_fixed_pattern,
  output logic [7:0] misc_ctrl_bus,
  output logic lock_declared,
  output logic comma_check_ok
);
  import chan_regs_pkg::*;

  logic [7:0] uncorr_hi_reg, uncorr_lo_reg, eq_bw_reg, refclk_edge_reg, eq_boost_reg;
  logic [7:0] comma_hi_reg, comma_lo_reg, rsvd_a_reg, rsvd_b_reg, pwr_a_reg, pwr_b_reg;
  logic [7:0] xpnt_reg, patt_hi_reg, rsvd_c_reg, div_a_reg, div_b_reg, eq_ctrl_reg;
  logic [BIT_CNT_W-1:0] bit_count_reg;
  logic [BIT_CNT_W-1:0] bit_count_snap_reg;
  logic [WINDOW_W-1:0] win_count_reg;
  logic [THRESH_W-1:0] comma_count_reg;
  logic comma_ok_reg;
  logic [WINDOW_W-1:0] win_len;
  logic [THRESH_W-1:0] thresh;
  logic win_end;
  logic check_active;
  logic [7:0] rd_next;
  logic wr_take;
  logic [THRESH_W:0] comma_total;

  // Write decode shared by all writable registers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Write strobe qualified once so every register block agrees on when a write lands
  assign wr_take = ce && wr_en;

  // Uncorrected-error pattern pair; stored for readback only, nothing inside uses it yet
  always_ff @(posedge clk) begin
    if (srst) begin
      uncorr_hi_reg <= RST_ZERO;
      uncorr_lo_reg <= RST_ZERO;
    end else if (wr_take) begin
      if (hit(addr, OFS_UNCORR_HI)) uncorr_hi_reg <= wr_data;
      if (hit(addr, OFS_UNCORR_LO)) uncorr_lo_reg <= wr_data;
    end
  end

  // Bandwidth byte; only bits 6 and 2 reach the equalizer, the rest is kept for readback
  always_ff @(posedge clk) begin
    if (srst) begin
      eq_bw_reg <= RST_EQ_BW;
    end else if (wr_take && hit(addr, OFS_EQ_BW)) begin
      eq_bw_reg <= wr_data;
    end
  end

  // Reference clock and driver byte; edge rate resets to all ones, gain to zero
  always_ff @(posedge clk) begin
    if (srst) begin
      refclk_edge_reg <= RST_REFCLK_EDGE;
    end else if (wr_take && hit(addr, OFS_REFCLK_EDGE)) begin
      refclk_edge_reg <= wr_data;
    end
  end

  // Window and threshold bytes; a change lands on the window already running
  always_ff @(posedge clk) begin
    if (srst) begin
      comma_hi_reg <= RST_ZERO;
      comma_lo_reg <= RST_ZERO;
    end else if (wr_take) begin
      if (hit(addr, OFS_COMMA_HI)) comma_hi_reg <= wr_data;
      if (hit(addr, OFS_COMMA_LO)) comma_lo_reg <= wr_data;
    end
  end

  // Reserved bytes are plain storage so the host reads back what it wrote
  always_ff @(posedge clk) begin
    if (srst) begin
      rsvd_a_reg <= RST_ZERO;
      rsvd_b_reg <= RST_ZERO;
      rsvd_c_reg <= RST_RSVD_C;
    end else if (wr_take) begin
      if (hit(addr, OFS_RSVD_A)) rsvd_a_reg <= wr_data;
      if (hit(addr, OFS_RSVD_B)) rsvd_b_reg <= wr_data;
      if (hit(addr, OFS_RSVD_C)) rsvd_c_reg <= wr_data;
    end
  end

  // Power override pair; only their combination leaves the block
  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_a_reg <= RST_ZERO;
      pwr_b_reg <= RST_ZERO;
    end else if (wr_take) begin
      if (hit(addr, OFS_PWR_A)) pwr_a_reg <= wr_data;
      if (hit(addr, OFS_PWR_B)) pwr_b_reg <= wr_data;
    end
  end

  // Crosspoint byte; master role, routing off and local buffer only out of reset
  always_ff @(posedge clk) begin
    if (srst) begin
      xpnt_reg <= RST_XPNT;
    end else if (wr_take && hit(addr, OFS_XPNT)) begin
      xpnt_reg <= wr_data;
    end
  end

  // Pattern upper byte is write-only; the read mux never selects it
  always_ff @(posedge clk) begin
    if (srst) begin
      patt_hi_reg <= RST_ZERO;
    end else if (wr_take && hit(addr, OFS_PATT_HI)) begin
      patt_hi_reg <= wr_data;
    end
  end

  // Divider override pair; kept as storage, the dividers themselves live elsewhere
  always_ff @(posedge clk) begin
    if (srst) begin
      div_a_reg <= RST_DIV;
      div_b_reg <= RST_DIV;
    end else if (wr_take) begin
      if (hit(addr, OFS_DIV_A)) div_a_reg <= wr_data;
      if (hit(addr, OFS_DIV_B)) div_b_reg <= wr_data;
    end
  end

  // Control source byte; only the two low bits steer the control bus
  always_ff @(posedge clk) begin
    if (srst) begin
      eq_ctrl_reg <= RST_ZERO;
    end else if (wr_take && hit(addr, OFS_EQ_CTRL_SRC)) begin
      eq_ctrl_reg <= wr_data;
    end
  end

  // Boost observation follows adaptation only; host writes never land here
  always_ff @(posedge clk) begin
    if (srst) eq_boost_reg <= RST_ZERO;
    else if (ce) eq_boost_reg <= eq_boost_adapt;
  end

  // Received-bit counter; clear is a level and wins over a tick in the same cycle
  always_ff @(posedge clk) begin
    if (srst || (ce && checker_count_clear)) begin
      bit_count_reg <= '0;
    end else if (ce && checker_bit_tick) begin
      bit_count_reg <= bit_count_reg + BIT_CNT_W'(1);
    end
  end

  // Readable snapshot trails the counter by a cycle and holds while frozen,
  // so six byte reads taken one after another still describe one instant
  always_ff @(posedge clk) begin
    if (srst || (ce && checker_count_clear)) begin
      bit_count_snap_reg <= '0;
    end else if (ce && !checker_count_freeze) begin
      bit_count_snap_reg <= bit_count_reg;
    end
  end

  // Window length and threshold decode
  always_comb begin
    win_len = WINDOW_W'(1) << (5'(comma_hi_reg[PERIOD_HI:PERIOD_LO]) + 5'(WINDOW_BASE_LOG2));
    thresh = {comma_hi_reg[3:0], comma_lo_reg};
    check_active = comma_lock_check_enable || block_lock_check_enable;
    // A window shortened mid-run closes at the next bit instead of running to wrap
    win_end = checker_bit_tick && (win_count_reg >= win_len - WINDOW_W'(1));
    comma_total = {1'b0, comma_count_reg} + (THRESH_W + 1)'(comma_seen);
  end

  // Window position in received bits; cleared whenever no check mode is on
  always_ff @(posedge clk) begin
    if (srst || (ce && !check_active)) begin
      win_count_reg <= '0;
    end else if (ce) begin
      if (win_end) begin
        win_count_reg <= '0;
      end else if (checker_bit_tick) begin
        win_count_reg <= win_count_reg + WINDOW_W'(1);
      end
    end
  end

  // Commas seen in the current window; saturates so a long window cannot wrap to a pass
  always_ff @(posedge clk) begin
    if (srst || (ce && !check_active)) begin
      comma_count_reg <= '0;
    end else if (ce) begin
      if (win_end) begin
        comma_count_reg <= '0;
      end else if (comma_seen && comma_count_reg != '1) begin
        comma_count_reg <= comma_count_reg + THRESH_W'(1);
      end
    end
  end

  // Verdict of the last complete window; a comma on its last bit still counts
  always_ff @(posedge clk) begin
    if (srst || (ce && !check_active)) begin
      comma_ok_reg <= 1'b0;
    end else if (ce && win_end) begin
      comma_ok_reg <= comma_total >= {1'b0, thresh};
    end
  end

  // Read mux; write-only and unmapped offsets read as zero
  always_comb begin
    rd_next = 8'h00;
    unique case (addr)
      OFS_CNT_BYTE5: rd_next = {1'b0, bit_count_snap_reg[46:40]};
      8'h86: rd_next = bit_count_snap_reg[39:32];
      8'h87: rd_next = bit_count_snap_reg[31:24];
      8'h88: rd_next = bit_count_snap_reg[23:16];
      8'h89: rd_next = bit_count_snap_reg[15:8];
      OFS_CNT_BYTE0: rd_next = bit_count_snap_reg[7:0];
      OFS_UNCORR_HI: rd_next = uncorr_hi_reg;
      OFS_UNCORR_LO: rd_next = uncorr_lo_reg;
      OFS_EQ_BW: rd_next = eq_bw_reg;
      OFS_REFCLK_EDGE: rd_next = refclk_edge_reg;
      OFS_EQ_BOOST: rd_next = eq_boost_reg;
      OFS_COMMA_HI: rd_next = comma_hi_reg;
      OFS_COMMA_LO: rd_next = comma_lo_reg;
      OFS_RSVD_A: rd_next = rsvd_a_reg;
      OFS_RSVD_B: rd_next = rsvd_b_reg;
      OFS_PWR_A: rd_next = pwr_a_reg;
      OFS_PWR_B: rd_next = pwr_b_reg;
      OFS_XPNT: rd_next = xpnt_reg;
      OFS_RSVD_C: rd_next = rsvd_c_reg;
      OFS_DIV_A: rd_next = div_a_reg;
      OFS_DIV_B: rd_next = div_b_reg;
      OFS_EQ_CTRL_SRC: rd_next = eq_ctrl_reg;
      default: rd_next = 8'h00;
    endcase
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en;
      if (rd_en) rd_data <= rd_next;
    end
  end

  // Bandwidth code from its two scattered bits; registered so the equalizer sees clean levels
  always_ff @(posedge clk) begin
    if (srst) begin
      eq_bandwidth <= BW_MID;
    end else if (ce) begin
      eq_bandwidth <= {eq_bw_reg[BW_MSB_BIT], eq_bw_reg[BW_LSB_BIT]};
    end
  end

  // Reference clock routing bits
  always_ff @(posedge clk) begin
    if (srst) begin
      refclk_out_source_select <= RST_REFCLK_EDGE[REFSEL_BIT];
      refclk_loopthrough_enable <= RST_REFCLK_EDGE[LOOPTHRU_BIT];
    end else if (ce) begin
      refclk_out_source_select <= refclk_edge_reg[REFSEL_BIT];
      refclk_loopthrough_enable <= refclk_edge_reg[LOOPTHRU_BIT];
    end
  end

  // Driver edge rate and receive gain
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_edge_rate_field <= RST_REFCLK_EDGE[EDGE_HI:EDGE_LO];
      rx_gain_field <= RST_REFCLK_EDGE[GAIN_HI:0];
    end else if (ce) begin
      tx_edge_rate_field <= refclk_edge_reg[EDGE_HI:EDGE_LO];
      rx_gain_field <= refclk_edge_reg[GAIN_HI:0];
    end
  end

  // Crosspoint role, routing, buffers and data source
  always_ff @(posedge clk) begin
    if (srst) begin
      crosspoint_role <= RST_XPNT[ROLE_BIT];
      crosspoint_enable <= RST_XPNT[XEN_BIT];
      eq_output_buffer_select <= RST_XPNT[BUF_HI:BUF_LO];
      eq_data_source_select <= RST_XPNT[1:0];
    end else if (ce) begin
      crosspoint_role <= xpnt_reg[ROLE_BIT];
      crosspoint_enable <= xpnt_reg[XEN_BIT];
      eq_output_buffer_select <= xpnt_reg[BUF_HI:BUF_LO];
      eq_data_source_select <= xpnt_reg[1:0];
    end
  end

  // Control bus source, same quad-member coding as the data source
  always_ff @(posedge clk) begin
    if (srst) begin
      eq_control_source_select <= RST_ZERO[1:0];
    end else if (ce) begin
      eq_control_source_select <= eq_ctrl_reg[1:0];
    end
  end

  // Low byte passes through from its own register outside this slice
  always_ff @(posedge clk) begin
    if (srst) begin
      generator_fixed_pattern <= 16'h0000;
    end else if (ce) begin
      generator_fixed_pattern <= {patt_hi_reg, gen_pattern_low};
    end
  end

  // Power overrides leave as one combined bus; both at reset gives all zeros
  always_ff @(posedge clk) begin
    if (srst) begin
      misc_ctrl_bus <= 8'h00;
    end else if (ce) begin
      misc_ctrl_bus <= pwr_a_reg ^ pwr_b_reg;
    end
  end

  // Comma detection is an extra lock condition only when its check is on;
  // with the check off, lock follows the raw loop lock one cycle late
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_declared <= 1'b0;
      comma_check_ok <= 1'b0;
    end else if (ce) begin
      lock_declared <= cdr_lock_raw && (!comma_lock_check_enable || comma_ok_reg);
      comma_check_ok <= comma_ok_reg;
    end
  end
endmodule
`default_nettype wire

// ---- tb/config_regs_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module config_regs_checker
  import chan_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] eq_boost_adapt,
  input wire logic comma_lock_check_enable,
  input wire logic cdr_lock_raw,
  input wire logic [1:0] eq_bandwidth,
  input wire logic [2:0] tx_edge_rate_field,
  input wire logic crosspoint_enable,
  input wire logic [15:0] generator_fixed_pattern,
  input wire logic lock_declared
);
  // Field checks wait two edges: register first, then the registered output
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_count_top_byte: assert property (ce && rd_en && addr == OFS_CNT_BYTE5 |=> rd_valid && !rd_data[7])
    else $error("count top byte bad");
  a_bw_code: assert property ((wr_en && ce && addr == OFS_EQ_BW ##1 ce) |=>
    eq_bandwidth == {$past(wr_data[6], 2), $past(wr_data[2], 2)}) else $error("bandwidth code bad");
  a_edge_field: assert property ((wr_en && ce && addr == OFS_REFCLK_EDGE ##1 ce) |=>
    tx_edge_rate_field == $past(wr_data[4:2], 2)) else $error("edge rate bad");
  a_xpnt_enable: assert property ((wr_en && ce && addr == OFS_XPNT ##1 ce) |=>
    crosspoint_enable == $past(wr_data[4], 2)) else $error("crosspoint enable bad");
  a_pattern_high: assert property ((wr_en && ce && addr == OFS_PATT_HI ##1 ce) |=>
    generator_fixed_pattern[15:8] == $past(wr_data, 2)) else $error("pattern high bad");
  a_pattern_hidden: assert property (ce && rd_en && addr == OFS_PATT_HI |=> rd_data == 8'h00)
    else $error("write-only byte readable");
  a_boost_read: assert property ($past(ce) && !$past(srst) && ce && rd_en && addr == OFS_EQ_BOOST |=>
    rd_data == $past(eq_boost_adapt, 2)) else $error("boost readback bad");
  a_lock_bypass: assert property (ce && !comma_lock_check_enable |=> lock_declared == $past(cdr_lock_raw))
    else $error("lock not following raw lock");
endmodule
bind retimer_channel_config_regs config_regs_checker chk (.clk, .srst, .ce, .wr_en, .rd_en, .addr, .wr_data,
  .rd_data, .rd_valid, .eq_boost_adapt, .comma_lock_check_enable, .cdr_lock_raw, .eq_bandwidth,
  .tx_edge_rate_field, .crosspoint_enable, .generator_fixed_pattern, .lock_declared);
`default_nettype wire

// ---- tb/link_source.sv ----
`timescale 1ns/10ps
`default_nettype none
module link_source (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  output logic tick,
  output logic comma,
  output logic [7:0] boost
);
  logic [1:0] phase_reg;
  // Bit per cycle while running; comma on every fourth bit so any window sees an exact count
  always_ff @(posedge clk) begin
    if (srst) begin
      {tick, comma, phase_reg} <= 4'h0;
    end else begin
      tick <= run;
      comma <= run && phase_reg == 2'h3;
      phase_reg <= phase_reg + 2'(run);
    end
  end
  // Adaptation steps only on commas, so it holds still while the host reads it
  always_ff @(posedge clk) begin
    if (srst) begin
      boost <= 8'h5A;
    end else if (comma) begin
      boost <= boost + 8'h11;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_retimer_channel_config_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_retimer_channel_config_regs;
  import chan_regs_pkg::*;
  logic clk, srst, ce, wr_en, rd_en, checker_bit_tick, checker_count_freeze, checker_count_clear, link_run;
  logic comma_lock_check_enable, block_lock_check_enable, comma_seen, cdr_lock_raw, rd_valid;
  logic refclk_out_source_select, refclk_loopthrough_enable, crosspoint_role, crosspoint_enable;
  logic lock_declared, comma_check_ok;
  logic [7:0] addr, wr_data, rd_data, gen_pattern_low, eq_boost_adapt, pat, misc_ctrl_bus;
  logic [1:0] eq_bandwidth, rx_gain_field, eq_output_buffer_select, eq_data_source_select, eq_control_source_select;
  logic [2:0] tx_edge_rate_field;
  logic [15:0] generator_fixed_pattern;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  logic [7:0] ra [8] = '{OFS_EQ_BW, OFS_REFCLK_EDGE, OFS_XPNT, OFS_DIV_A, OFS_DIV_B, OFS_COMMA_HI, 8'h9B, 8'h92};
  logic [7:0] rv [8] = '{8'h06, 8'h1C, 8'h04, 8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00};
  logic [7:0] ch [4] = '{8'h00, 8'h00, 8'h10, 8'h11};
  logic [7:0] cl [4] = '{8'h08, 8'h09, 8'h09, 8'h09};
  logic [3:0] cx = 4'b0101;
  retimer_channel_config_regs uut (.clk, .srst, .ce, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
    .gen_pattern_low, .checker_bit_tick, .checker_count_freeze, .checker_count_clear, .eq_boost_adapt,
    .comma_lock_check_enable, .block_lock_check_enable, .comma_seen, .cdr_lock_raw, .eq_bandwidth,
    .refclk_out_source_select, .refclk_loopthrough_enable, .tx_edge_rate_field, .rx_gain_field, .crosspoint_role,
    .crosspoint_enable, .eq_output_buffer_select, .eq_data_source_select, .eq_control_source_select,
    .generator_fixed_pattern, .misc_ctrl_bus, .lock_declared, .comma_check_ok);
  link_source peer (.clk, .srst, .run(link_run), .tick(checker_bit_tick), .comma(comma_seen), .boost(eq_boost_adapt));
  task complete_run();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Extra idle cycle lets the registered field outputs follow the register
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr_en, addr, wr_data} = {1'b1, a, d};
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk);
    rd_en = 1'b0;
    check(16'(rd_valid), 16'h1);
    check(16'(rd_data), 16'(exp));
  endtask
  task pump(input int n);
    link_run = 1'b1;
    repeat (n) @(negedge clk);
    link_run = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard well above the roughly 1200 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {srst, ce, wr_en, rd_en, checker_count_freeze, checker_count_clear, link_run} = 7'b1100000;
    {comma_lock_check_enable, block_lock_check_enable, cdr_lock_raw, addr, wr_data} = 19'h0;
    gen_pattern_low = 8'h3C;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    check(16'({eq_bandwidth, tx_edge_rate_field, eq_output_buffer_select}), 16'h3D);
    check(16'({crosspoint_role, crosspoint_enable}), 16'h0);
    check(16'(misc_ctrl_bus), 16'h00);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_EQ_BW, 8'((i / 2) * 64 + (i % 2) * 4 + 2));
      check(16'(eq_bandwidth), 16'(i));
      wr(OFS_XPNT, 8'(i * 21));
      check(16'({crosspoint_role, crosspoint_enable, eq_output_buffer_select, eq_data_source_select}), 16'(i * 21));
      wr(OFS_EQ_CTRL_SRC, 8'(i));
      check(16'(eq_control_source_select), 16'(i));
    end
    for (int k = 0; k < 2; k++) begin
      pat = 8'(8'h55 << k) & 8'h7F;
      wr(OFS_REFCLK_EDGE, pat);
      check(16'({refclk_out_source_select, refclk_loopthrough_enable, tx_edge_rate_field, rx_gain_field}), 16'(pat[6:0]));
      rd(OFS_REFCLK_EDGE, pat);
    end
    wr(OFS_PATT_HI, 8'hA5);
    check(generator_fixed_pattern, 16'hA53C);
    rd(OFS_PATT_HI, 8'h00);
    wr(OFS_EQ_BOOST, 8'hFF);
    rd(OFS_EQ_BOOST, 8'h5A);
    // Write offered while stalled must not land
    ce = 1'b0;
    wr(OFS_XPNT, 8'h00);
    ce = 1'b1;
    rd(OFS_XPNT, 8'h3F);
    checker_count_clear = 1'b1;
    @(negedge clk);
    checker_count_clear = 1'b0;
    pump(40);
    checker_count_freeze = 1'b1;
    pump(10);
    rd(OFS_CNT_BYTE0, 8'h28);
    for (int a = 0; a < 5; a++) rd(8'(OFS_CNT_BYTE5 + a), 8'h00);
    // Exactly 8 commas per 32 bits: threshold 8 passes, 9 fails, wider window passes 9 but fails 265
    {cdr_lock_raw, comma_lock_check_enable} = 2'b11;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_COMMA_HI, ch[i]);
      wr(OFS_COMMA_LO, cl[i]);
      rd(OFS_COMMA_LO, cl[i]);
      pump(200);
      check(16'(comma_check_ok), 16'(cx[i]));
      check(16'(lock_declared), 16'(cx[i]));
    end
    comma_lock_check_enable = 1'b0;
    repeat (2) @(negedge clk);
    check(16'(lock_declared), 16'h1);
    check(16'(comma_check_ok), 16'h0);
    // Block-code lock check alone must still run the window
    block_lock_check_enable = 1'b1;
    wr(OFS_COMMA_HI, 8'h10);
    pump(200);
    check(16'(comma_check_ok), 16'h1);
    complete_run();
  end
endmodule
`default_nettype wire
